// ---- shared/mdl_pkg.sv ----
// shared constants and types for the measurement data logger
package mdl_pkg;

    // data widths and store depths
    localparam int SAMPLE_W   = 16;
    localparam int DATA_DEPTH = 4096;
    localparam int DATA_AW    = 12;
    localparam int DATA_CW    = 13;
    localparam int EVT_DEPTH  = 100;
    localparam int EVT_AW     = 7;
    localparam int EVT_CW     = 7;
    localparam int FIFO_DEPTH = 4;

    // wishbone register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_PERIOD  = 8'h04;
    localparam logic [7:0] REG_THRESH  = 8'h08;
    localparam logic [7:0] REG_SPAN    = 8'h0C;
    localparam logic [7:0] REG_CMD     = 8'h10;
    localparam logic [7:0] REG_STATUS  = 8'h14;
    localparam logic [7:0] REG_DCOUNT  = 8'h18;
    localparam logic [7:0] REG_ECOUNT  = 8'h1C;
    localparam logic [7:0] REG_LAST    = 8'h20;
    localparam logic [7:0] REG_DIDX    = 8'h24;
    localparam logic [7:0] REG_DDATA   = 8'h28;
    localparam logic [7:0] REG_EIDX    = 8'h2C;
    localparam logic [7:0] REG_EDATA   = 8'h30;

    // control, command and status bit positions
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_AVG_BIT   = 1;
    localparam int CTRL_TRIG_BIT  = 2;
    localparam int CTRL_ROLL_BIT  = 3;
    localparam int CMD_CLRD_BIT   = 0;
    localparam int CMD_CLRE_BIT   = 1;
    localparam int STAT_DFULL_BIT = 0;
    localparam int STAT_EFULL_BIT = 1;
    localparam int STAT_WARN_BIT  = 2;

    // values after reset
    localparam logic [31:0] PERIOD_RST = 32'h0000_0064;
    localparam logic [15:0] THRESH_RST = 16'h0000;
    localparam logic [15:0] SPAN_RST   = 16'hFFFF;

    // averaging divider runs one quotient bit per cycle
    localparam logic [4:0] DIV_LAST_STEP = 5'h1F;

    typedef enum logic [1:0] {
        MDL_RUN    = 2'b00,
        MDL_DIV    = 2'b01,
        MDL_COMMIT = 2'b10
    } mdl_state_t;

endpackage : mdl_pkg

// ---- logic/mdl_fifo.sv ----
// small sample fifo with valid/ready on both sides
`timescale 1ns/1ps
module mdl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,      // system clock
    input  wire logic             rst_b,    // sync reset, active low
    input  wire logic             inValid,  // producer has a word
    input  wire logic [WIDTH-1:0] inData,   // producer word
    output logic                  inReady,  // room for a word
    output logic                  outValid, // word available
    output logic      [WIDTH-1:0] outData,  // oldest word
    input  wire logic             outReady  // consumer takes word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] rdPtr;
        logic [AW-1:0] wrPtr;
        logic [AW:0]   count;
        logic          inReady;
        logic          outValid;
    } mdl_fifo_st_t;

    mdl_fifo_st_t s;
    mdl_fifo_st_t s_n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // pointer and flag update, flags held in flops
    always_comb
    begin
        s_n = s;
        push = inValid && s.inReady;
        pop = s.outValid && outReady;
        if (push)
            s_n.wrPtr = s.wrPtr + 1'b1;
        if (pop)
            s_n.rdPtr = s.rdPtr + 1'b1;
        s_n.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
        s_n.inReady = s_n.count < (AW+1)'(DEPTH);
        s_n.outValid = s_n.count != '0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            s <= '{rdPtr: '0, wrPtr: '0, count: '0, inReady: 1'b1, outValid: 1'b0};
        else
            s <= s_n;
    end

    // storage write
    always_ff @(posedge clk)
    begin
        if (push)
            mem[s.wrPtr] <= inData;
    end

    assign inReady = s.inReady;
    assign outValid = s.outValid;
    assign outData = mem[s.rdPtr];

endmodule : mdl_fifo

// ---- logic/mdl_store.sv ----
// bounded entry store with roll or stack overflow
`timescale 1ns/1ps
module mdl_store #(
    parameter int W     = 16,
    parameter int DEPTH = 4096,
    parameter int AW    = 12,
    parameter int CW    = 13
) (
    input  wire logic          clk,      // system clock
    input  wire logic          rst_b,    // sync reset, active low
    input  wire logic          rollMode, // 1 overwrite oldest, 0 stack
    input  wire logic          clear,    // discard all entries
    input  wire logic          wrEn,     // entry offered
    input  wire logic [W-1:0]  wrData,   // entry value
    input  wire logic [CW-1:0] rdIdx,    // index from oldest
    output logic      [W-1:0]  rdData,   // entry at index, 0 if none
    output logic      [CW-1:0] count,    // entries held
    output logic               full,     // store full
    output logic               accept    // entry written this cycle
);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [CW-1:0] count;
        logic          full;
    } mdl_store_st_t;

    mdl_store_st_t s;
    mdl_store_st_t s_n;
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wrAddr;
    logic [AW-1:0] oldest;

    // circular address add, offset never above depth
    function automatic logic [AW-1:0] mdlWrap(input logic [AW-1:0] base, input logic [CW-1:0] off);
        int sum;
        sum = int'(base) + int'(off);
        if (sum >= DEPTH)
            sum = sum - DEPTH;
        return AW'(sum);
    endfunction : mdlWrap

    // accept, clear and fill tracking; a write in the clear cycle survives
    always_comb
    begin
        s_n = s;
        accept = wrEn && (clear || !s.full || rollMode);
        wrAddr = clear ? '0 : s.wrPtr;
        if (clear)
        begin
            s_n.wrPtr = accept ? AW'(1) : '0;
            s_n.count = accept ? CW'(1) : '0;
            s_n.full = 1'b0;
        end
        else if (accept)
        begin
            s_n.wrPtr = mdlWrap(s.wrPtr, CW'(1));
            if (!s.full)
                s_n.count = s.count + CW'(1);
            s_n.full = s.full || (s.count + CW'(1) == DEPTH_C);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            s <= '{wrPtr: '0, count: '0, full: 1'b0};
        else
            s <= s_n;
    end

    // entry storage
    always_ff @(posedge clk)
    begin
        if (accept)
            mem[wrAddr] <= wrData;
    end

    // read by age, oldest entry at index 0
    assign oldest = mdlWrap(s.wrPtr, DEPTH_C - s.count);
    assign rdData = (rdIdx < s.count) ? mem[mdlWrap(oldest, rdIdx)] : '0;
    assign count = s.count;
    assign full = s.full;

    a_stack_reject: assert property (@(posedge clk) disable iff (!rst_b)
        s.full && !rollMode && wrEn && !clear |=> s.count == $past(s.count) && s.wrPtr == $past(s.wrPtr))
        else $error("stack store changed while full");

    a_roll_advance: assert property (@(posedge clk) disable iff (!rst_b)
        s.full && rollMode && wrEn && !clear |=> s.full && s.wrPtr == mdlWrap($past(s.wrPtr), CW'(1)))
        else $error("roll store did not overwrite oldest");

    a_clear_empty: assert property (@(posedge clk) disable iff (!rst_b)
        clear && !wrEn |=> s.count == '0 && !s.full && s.wrPtr == '0)
        else $error("clear left entries");

    a_depth_bound: assert property (@(posedge clk) disable iff (!rst_b)
        s.count <= DEPTH_C && (s.full == (s.count == DEPTH_C)))
        else $error("fill count out of step with depth");

endmodule : mdl_store

// ---- logic/mdl_logger.sv ----
// measurement data logger: reduction, trigger, stores and wishbone registers
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - peak mode stores period maximum
// - average mode stores period mean
// - trigger criterion switched independently
// - trigger on: store only if deviation exceeds threshold or measurement store is empty
// - threshold is fraction times range span
// - reference is last value actually stored
// - trigger off: store every period result
// - one stack/roll setting for both stores
// - roll: new entry overwrites oldest
// - stack: full store rejects entries
// - stack full raises warning
// - clear command empties measurement store
// - clear command empties event store
// - measurement store holds 3000 or more
// - event store holds at most 100
// - disabled logger writes nothing
// - sample period length is configurable
module mdl_logger (
    input  wire logic        clk,         // system clock, 20 MHz
    input  wire logic        rst_b,       // sync reset, active low
    input  wire logic        wb_cyc_i,    // wishbone cycle
    input  wire logic        wb_stb_i,    // wishbone strobe
    input  wire logic        wb_we_i,     // wishbone write
    input  wire logic [7:0]  wb_adr_i,    // byte address
    input  wire logic [3:0]  wb_sel_i,    // byte enables
    input  wire logic [31:0] wb_dat_i,    // write data
    output logic      [31:0] wb_dat_o,    // read data
    output logic             wb_ack_o,    // acknowledge
    input  wire logic        sampleValid, // concentration sample offered
    input  wire logic [15:0] sampleData,  // concentration sample
    output logic             sampleReady, // sample taken when high
    input  wire logic        eventValid,  // event pulse
    input  wire logic [15:0] eventCode,   // event record
    output logic             logWarn      // stack store full warning
);
    typedef struct packed {
        mdl_pkg::mdl_state_t state;
        logic        enable;
        logic        avgMode;
        logic        trigEn;
        logic        rollMode;
        logic [31:0] period;
        logic [15:0] thresh;
        logic [15:0] span;
        logic [31:0] timer;
        logic [15:0] peak;
        logic [31:0] sum;
        logic [15:0] cnt;
        logic [31:0] divNum;
        logic [15:0] divDen;
        logic [15:0] rem;
        logic [4:0]  divCnt;
        logic [15:0] result;
        logic [15:0] lastStored;
        logic        clrData;
        logic        clrEvt;
        logic [12:0] dataIdx;
        logic [6:0]  evtIdx;
        logic        ack;
        logic [31:0] rdData;
        logic        warn;
    } mdl_logger_st_t;

    mdl_logger_st_t s;
    mdl_logger_st_t s_n;

    logic        fifoValid;
    logic [15:0] fifoData;
    logic        popReady;
    logic        popFire;
    logic        periodEnd;
    logic [16:0] remShift;
    logic        qBit;
    logic [31:0] product;
    logic [15:0] limit;
    logic [15:0] diff;
    logic        dataWr;
    logic        evtWr;
    logic        dataAccept;
    logic [15:0] dataRd;
    logic [15:0] evtRd;
    logic [12:0] dataCount;
    logic [6:0]  evtCount;
    logic        dataFull;
    logic        evtFull;
    logic        req;
    logic [31:0] ctrlWord;
    logic [31:0] merged;

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] mdlMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction : mdlMerge

    // sample buffer, drained only while accumulating
    mdl_fifo #(
        .WIDTH (mdl_pkg::SAMPLE_W),
        .DEPTH (mdl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_b    (rst_b),
        .inValid  (sampleValid),
        .inData   (sampleData),
        .inReady  (sampleReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (popReady)
    );

    // measurement store
    mdl_store #(
        .W     (mdl_pkg::SAMPLE_W),
        .DEPTH (mdl_pkg::DATA_DEPTH),
        .AW    (mdl_pkg::DATA_AW),
        .CW    (mdl_pkg::DATA_CW)
    ) u_data (
        .clk      (clk),
        .rst_b    (rst_b),
        .rollMode (s.rollMode),
        .clear    (s.clrData),
        .wrEn     (dataWr),
        .wrData   (s.result),
        .rdIdx    (s.dataIdx),
        .rdData   (dataRd),
        .count    (dataCount),
        .full     (dataFull),
        .accept   (dataAccept)
    );

    // event store, same overflow setting
    mdl_store #(
        .W     (mdl_pkg::SAMPLE_W),
        .DEPTH (mdl_pkg::EVT_DEPTH),
        .AW    (mdl_pkg::EVT_AW),
        .CW    (mdl_pkg::EVT_CW)
    ) u_evt (
        .clk      (clk),
        .rst_b    (rst_b),
        .rollMode (s.rollMode),
        .clear    (s.clrEvt),
        .wrEn     (evtWr),
        .wrData   (eventCode),
        .rdIdx    (s.evtIdx),
        .rdData   (evtRd),
        .count    (evtCount),
        .full     (evtFull),
        .accept   ()
    );

    // trigger threshold and deviation from last stored entry
    assign product = s.thresh * s.span;
    assign limit = product[31:16];
    assign diff = (s.result >= s.lastStored) ? s.result - s.lastStored : s.lastStored - s.result;
    assign dataWr = (s.state == mdl_pkg::MDL_COMMIT) && s.enable
        && (!s.trigEn || dataCount == '0 || diff > limit);
    assign evtWr = eventValid && s.enable;

    // sample intake and period timing
    assign popReady = s.state == mdl_pkg::MDL_RUN;
    assign popFire = fifoValid && popReady;
    assign periodEnd = popReady && (s.timer + 32'h0000_0001 >= s.period);
    assign remShift = {s.rem, s.divNum[31]};
    assign qBit = remShift >= {1'b0, s.divDen};
    assign req = wb_cyc_i && wb_stb_i && !s.ack;
    assign ctrlWord = {28'h0000_000, s.rollMode, s.trigEn, s.avgMode, s.enable};
    assign merged = mdlMerge((wb_adr_i == mdl_pkg::REG_CTRL) ? ctrlWord :
                             (wb_adr_i == mdl_pkg::REG_PERIOD) ? s.period :
                             (wb_adr_i == mdl_pkg::REG_THRESH) ? {16'h0000, s.thresh} :
                             (wb_adr_i == mdl_pkg::REG_SPAN) ? {16'h0000, s.span} :
                             (wb_adr_i == mdl_pkg::REG_DIDX) ? {19'h00000, s.dataIdx} :
                             (wb_adr_i == mdl_pkg::REG_EIDX) ? {25'h0000000, s.evtIdx} : 32'h0000_0000,
                             wb_dat_i, wb_sel_i);

    // reduction state machine, divider and register file
    always_comb
    begin
        s_n = s;
        s_n.ack = 1'b0;
        s_n.clrData = 1'b0;
        s_n.clrEvt = 1'b0;
        unique case (s.state)
            mdl_pkg::MDL_RUN:
            begin
                s_n.timer = periodEnd ? 32'h0000_0000 : s.timer + 32'h0000_0001;
                if (periodEnd)
                begin
                    if (s.cnt != 16'h0000)
                    begin
                        s_n.divNum = s.sum;
                        s_n.divDen = s.cnt;
                        s_n.rem = 16'h0000;
                        s_n.divCnt = mdl_pkg::DIV_LAST_STEP;
                        s_n.result = s.peak;
                        s_n.state = s.avgMode ? mdl_pkg::MDL_DIV : mdl_pkg::MDL_COMMIT;
                    end
                    s_n.peak = popFire ? fifoData : 16'h0000;
                    s_n.sum = popFire ? {16'h0000, fifoData} : 32'h0000_0000;
                    s_n.cnt = popFire ? 16'h0001 : 16'h0000;
                end
                else if (popFire)
                begin
                    if (fifoData > s.peak)
                        s_n.peak = fifoData;
                    if (s.cnt != 16'hFFFF)
                    begin
                        s_n.sum = s.sum + {16'h0000, fifoData};
                        s_n.cnt = s.cnt + 16'h0001;
                    end
                end
            end
            mdl_pkg::MDL_DIV:
            begin
                s_n.rem = qBit ? 16'(remShift - {1'b0, s.divDen}) : remShift[15:0];
                s_n.divNum = {s.divNum[30:0], qBit};
                s_n.divCnt = s.divCnt - 5'h01;
                if (s.divCnt == 5'h00)
                begin
                    s_n.result = s_n.divNum[15:0];
                    s_n.state = mdl_pkg::MDL_COMMIT;
                end
            end
            mdl_pkg::MDL_COMMIT:
            begin
                if (dataAccept)
                    s_n.lastStored = s.result;
                s_n.state = mdl_pkg::MDL_RUN;
            end
            default:
                s_n.state = mdl_pkg::MDL_RUN;
        endcase
        s_n.warn = !s.rollMode && (dataFull || evtFull);
        if (req)
        begin
            s_n.ack = 1'b1;
            s_n.rdData = 32'h0000_0000;
            if (wb_we_i)
            begin
                unique case (wb_adr_i)
                    mdl_pkg::REG_CTRL:
                    begin
                        s_n.enable = merged[mdl_pkg::CTRL_EN_BIT];
                        s_n.avgMode = merged[mdl_pkg::CTRL_AVG_BIT];
                        s_n.trigEn = merged[mdl_pkg::CTRL_TRIG_BIT];
                        s_n.rollMode = merged[mdl_pkg::CTRL_ROLL_BIT];
                    end
                    mdl_pkg::REG_PERIOD: s_n.period = merged;
                    mdl_pkg::REG_THRESH: s_n.thresh = merged[15:0];
                    mdl_pkg::REG_SPAN: s_n.span = merged[15:0];
                    mdl_pkg::REG_CMD:
                    begin
                        s_n.clrData = wb_sel_i[0] && wb_dat_i[mdl_pkg::CMD_CLRD_BIT];
                        s_n.clrEvt = wb_sel_i[0] && wb_dat_i[mdl_pkg::CMD_CLRE_BIT];
                    end
                    mdl_pkg::REG_DIDX: s_n.dataIdx = merged[12:0];
                    mdl_pkg::REG_EIDX: s_n.evtIdx = merged[6:0];
                    default: ;
                endcase
            end
            else
            begin
                unique case (wb_adr_i)
                    mdl_pkg::REG_CTRL: s_n.rdData = ctrlWord;
                    mdl_pkg::REG_PERIOD: s_n.rdData = s.period;
                    mdl_pkg::REG_THRESH: s_n.rdData = {16'h0000, s.thresh};
                    mdl_pkg::REG_SPAN: s_n.rdData = {16'h0000, s.span};
                    mdl_pkg::REG_STATUS: s_n.rdData = {29'h0000000, s.warn, evtFull, dataFull};
                    mdl_pkg::REG_DCOUNT: s_n.rdData = {19'h00000, dataCount};
                    mdl_pkg::REG_ECOUNT: s_n.rdData = {25'h0000000, evtCount};
                    mdl_pkg::REG_LAST: s_n.rdData = {16'h0000, s.lastStored};
                    mdl_pkg::REG_DIDX: s_n.rdData = {19'h00000, s.dataIdx};
                    mdl_pkg::REG_DDATA: s_n.rdData = {16'h0000, dataRd};
                    mdl_pkg::REG_EIDX: s_n.rdData = {25'h0000000, s.evtIdx};
                    mdl_pkg::REG_EDATA: s_n.rdData = {16'h0000, evtRd};
                    default: s_n.rdData = 32'h0000_0000;
                endcase
            end
        end
    end

    // state register with reset values
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            s <= '0;
            s.state <= mdl_pkg::MDL_RUN;
            s.period <= mdl_pkg::PERIOD_RST;
            s.thresh <= mdl_pkg::THRESH_RST;
            s.span <= mdl_pkg::SPAN_RST;
        end
        else
            s <= s_n;
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdData;
    assign logWarn = s.warn;

    sequence divEntry;
        s.state != mdl_pkg::MDL_DIV ##1 s.state == mdl_pkg::MDL_DIV;
    endsequence

    sequence divDone;
        ##32 s.state == mdl_pkg::MDL_COMMIT;
    endsequence

    a_div_length: assert property (@(posedge clk) disable iff (!rst_b) divEntry |-> divDone)
        else $error("average divider took wrong number of cycles");

    a_avg_mean: assert property (@(posedge clk) disable iff (!rst_b)
        s.state == mdl_pkg::MDL_COMMIT && s.avgMode && $past(s.state) == mdl_pkg::MDL_DIV
        |-> 48'(s.result) * 48'(s.divDen) <= 48'($past(s.sum, 33))
            && 48'($past(s.sum, 33)) < (48'(s.result) + 48'd1) * 48'(s.divDen))
        else $error("stored average is not the mean");

    a_peak_track: assert property (@(posedge clk) disable iff (!rst_b)
        popFire && !periodEnd && fifoData > s.peak |=> s.peak == $past(fifoData))
        else $error("peak missed a larger sample");

    a_idle_nowrite: assert property (@(posedge clk) disable iff (!rst_b)
        !s.enable |-> !dataWr && !evtWr)
        else $error("disabled logger wrote an entry");

    a_trig_reject: assert property (@(posedge clk) disable iff (!rst_b)
        s.trigEn && dataCount != '0 && diff <= limit |-> !dataWr)
        else $error("entry within threshold was stored");

    a_untrig_store: assert property (@(posedge clk) disable iff (!rst_b)
        s.state == mdl_pkg::MDL_COMMIT && s.enable && !s.trigEn |-> dataWr)
        else $error("period result dropped with trigger off");

    a_ref_update: assert property (@(posedge clk) disable iff (!rst_b)
        dataWr && !dataAccept |=> s.lastStored == $past(s.lastStored))
        else $error("reference moved without a stored entry");

    a_warn_stack: assert property (@(posedge clk) disable iff (!rst_b)
        !s.rollMode && dataFull ##1 !s.rollMode && dataFull |-> s.warn)
        else $error("stack full without warning");

endmodule : mdl_logger

// ---- test/mdl_sample_src.sv ----
// sample source standing in for the measurement path
`timescale 1ns/1ps
module mdl_sample_src (
    input  wire logic        clk,   // system clock
    input  wire logic        run,   // offer samples
    input  wire logic        dense, // offer every cycle
    input  wire logic        ready, // logger takes sample
    output logic             valid, // sample offered
    output logic      [15:0] data   // sample, toggles idle
);
    integer      seed = 87194;
    logic [31:0] r;
    // hold an offer until taken; idle data changes every cycle
    always @(posedge clk)
    begin
        r = $random(seed);
        if (!valid || ready)
            valid <= run && (dense || r[0]);
        data <= (valid && !ready) ? data : (run ? {6'h00, r[9:0]} : ~data);
    end
    initial valid = 1'b0;
    initial data = 16'h0000;
endmodule : mdl_sample_src

// ---- test/mdl_logger_test.sv ----
// self-checking bench for the measurement data logger
`timescale 1ns/1ps
module mdl_logger_test;
    localparam int LIM = (32'h8000 * 32'h3E8) >> 16;
    logic        clk = 0, rst_b = 0, cyc = 0, we = 0, run = 0, dense = 0, evV = 0;
    logic        ack, sv, sr, warn;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dout;
    logic [15:0] sd, evC = 16'h0000;
    int          errorCnt = 0, checkCount = 0, q[$], lastV, cnt = 0, n, r;
    mdl_logger dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
        .sampleValid(sv), .sampleData(sd), .sampleReady(sr), .eventValid(evV),
        .eventCode(evC), .logWarn(warn));
    mdl_sample_src src (.clk(clk), .run(run), .dense(dense), .ready(sr), .valid(sv), .data(sd));
    initial
    begin
        forever #25 clk = ~clk;
    end
    // model input: every sample the logger takes
    always @(posedge clk)
    begin
        if (sv && sr)
            q.push_back(sd);
    end
    task automatic tallyAndFinish(bit hung);
        errorCnt += hung;
        if (errorCnt == 0 && checkCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tallyAndFinish
    task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
        checkCount++;
        if (s !== e)
        begin
            errorCnt++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : cmp
    // one classic cycle, held until ack is seen
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        int t = 0;
        @(posedge clk);
        cyc <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (ack !== 1'b1 && t < 50);
        if (ack !== 1'b1)
            tallyAndFinish(1);
        rdat = dout;
        cyc <= 0;
        we <= 0;
    endtask : wb
    task automatic rc(logic [7:0] a, logic [31:0] e);
        wb(0, a, 0);
        cmp($sformatf("reg %h", a), e, rdat);
    endtask : rc
    task automatic tick(int k);
        repeat (k) @(posedge clk);
    endtask : tick
    task automatic waitCount(int c);
        int t = 0;
        do
        begin
            wb(0, mdl_pkg::REG_DCOUNT, 0);
            t++;
        end
        while (rdat !== c && t < 9000);
        cmp("dcount", c, rdat);
        if (rdat !== c)
            tallyAndFinish(1);
    endtask : waitCount
    // lone sample, trigger off so it is always stored, fixes the period phase; then a burst is reduced
    task automatic period(logic avg, logic trig);
        wb(1, mdl_pkg::REG_CTRL, {28'h0, 1'b0, 1'b0, avg, 1'b1});
        q = {};
        run <= 1;
        dense <= 1;
        @(posedge clk);
        run <= 0;
        dense <= 0;
        waitCount(++cnt);
        wb(1, mdl_pkg::REG_CTRL, {28'h0, 1'b0, trig, avg, 1'b1});
        lastV = q[0];
        q = {};
        run <= 1;
        tick(24);
        run <= 0;
        tick(400);
        r = 0;
        foreach (q[i]) r = avg ? r + q[i] : (q[i] > r ? q[i] : r);
        if (avg)
            r = r / q.size();
        if (!trig || (r > lastV ? r - lastV : lastV - r) > LIM)
        begin
            cnt++;
            lastV = r;
        end
        rc(mdl_pkg::REG_DCOUNT, cnt);
        rc(mdl_pkg::REG_LAST, lastV);
    endtask : period
    initial
    begin
        tick(16);
        rst_b <= 1;
        rc(mdl_pkg::REG_CTRL, 0);
        rc(mdl_pkg::REG_PERIOD, 32'h64);
        rc(mdl_pkg::REG_SPAN, 32'hFFFF);
        rc(8'h3C, 0);
        wb(1, mdl_pkg::REG_PERIOD, 32'h12C);
        wb(1, mdl_pkg::REG_THRESH, 32'h8000);
        wb(1, mdl_pkg::REG_SPAN, 32'h3E8);
        for (int k = 0; k < 8; k++) period(k[0], k[1]);
        // fill in stack mode, then roll, then clear
        wb(1, mdl_pkg::REG_PERIOD, 32'h1);
        wb(1, mdl_pkg::REG_CTRL, 32'h1);
        run <= 1;
        dense <= 1;
        waitCount(mdl_pkg::DATA_DEPTH);
        wb(0, mdl_pkg::REG_DDATA, 0);
        n = rdat;
        tick(100);
        rc(mdl_pkg::REG_DDATA, n);
        rc(mdl_pkg::REG_DCOUNT, mdl_pkg::DATA_DEPTH);
        cmp("warn", 1, warn);
        wb(1, mdl_pkg::REG_CTRL, 32'h9);
        tick(100);
        cmp("warn", 0, warn);
        rc(mdl_pkg::REG_DCOUNT, mdl_pkg::DATA_DEPTH);
        wb(0, mdl_pkg::REG_DDATA, 0);
        cmp("oldest", 1, rdat !== n);
        run <= 0;
        tick(20);
        wb(1, mdl_pkg::REG_CMD, 32'h1);
        rc(mdl_pkg::REG_DCOUNT, 0);
        rc(mdl_pkg::REG_DDATA, 0);
        // event store overflow in stack mode
        wb(1, mdl_pkg::REG_CTRL, 32'h1);
        for (int i = 0; i < 110; i++)
        begin
            evV <= 1;
            evC <= i[15:0];
            @(posedge clk);
        end
        evV <= 0;
        tick(3);
        rc(mdl_pkg::REG_ECOUNT, mdl_pkg::EVT_DEPTH);
        rc(mdl_pkg::REG_EDATA, 0);
        cmp("warn", 1, warn);
        wb(1, mdl_pkg::REG_CMD, 32'h2);
        rc(mdl_pkg::REG_ECOUNT, 0);
        cmp("warn", 0, warn);
        // disabled logger stores nothing
        wb(1, mdl_pkg::REG_CTRL, 32'h0);
        run <= 1;
        evV <= 1;
        tick(40);
        run <= 0;
        evV <= 0;
        tick(20);
        rc(mdl_pkg::REG_DCOUNT, 0);
        rc(mdl_pkg::REG_ECOUNT, 0);
        tallyAndFinish(0);
    end
endmodule : mdl_logger_test
